/* design/gpio_lines.sv */
/*
 General-purpose line block with alternate-function multiplexing and an APB slave.
 Assumes synchronous pin levels, an APB master on clk and one synchronous reset.
*/
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
module gpio_lines
(
   input  wire logic                  clk,
   input  wire logic                  reset,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   input  wire logic [3:0]            pstrb,
   output      logic                  pready,
   output      logic [31:0]           prdata,
   output      logic                  pslverr,
   input  wire gpio_pkg::line_in_t    pinIn,
   output      gpio_pkg::line_out_t   pinOut,
   output      logic [16:0]           pullUpEn,
   input  wire gpio_pkg::alt_drive_t  altDrive,
   output      gpio_pkg::alt_sense_t  altSense
);

   // ==========================================================================
   // Helpers
   function automatic logic [16:0] onehot(input logic [4:0] idx);
      logic [16:0] r;
      r = '0;
      if (idx < 5'(gpio_pkg::NUM_LINES))
         r[idx] = 1'b1;
      return r;
   endfunction : onehot

   function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (st[b])
            r[8*b +: 8] = wd[8*b +: 8];
      return r;
   endfunction : mergeBytes

   // ==========================================================================
   // State
   gpio_pkg::gpio_state_t state_reg;
   gpio_pkg::gpio_state_t state_next;

   logic [16:0] driveMask;
   logic [16:0] driveValue;
   logic [16:0] forceIn;
   logic [31:0] routeWord;
   logic [31:0] mergedWord;
   logic        access;
   logic [4:0]  sel;

   assign pready   = 1'b1;
   assign prdata   = state_reg.prdata;
   assign pslverr  = state_reg.pslverr;
   assign pinOut   = state_reg.pins;
   assign pullUpEn = '1;
   assign access   = psel && penable;

   // ==========================================================================
   // Alternate-function mux
   always_comb
   begin
      driveMask  = state_reg.outEnable;
      driveValue = state_reg.outValue;
      forceIn    = '0;
      for (int p = 0; p < gpio_pkg::NUM_SERIAL; p++)
      begin
         if (state_reg.altEnable[p])
         begin
            forceIn = forceIn | onehot(gpio_pkg::RX_LINE[p]);
            driveMask  = driveMask | onehot(gpio_pkg::TX_LINE[p]);
            sel = gpio_pkg::TX_LINE[p];
            driveValue[sel] = altDrive.tx[p];
            if (state_reg.rtsMapEn[p])
            begin
               sel = state_reg.rtsSel[p];
               if (sel >= 5'(gpio_pkg::UPPER_BASE) && sel <= 5'(gpio_pkg::UNPORTED))
                  driveValue[sel] = altDrive.rts[p];
            end
         end
      end
      sel = 5'(gpio_pkg::UNPORTED);
      if (state_reg.altEnable[gpio_pkg::ALT_SQUARE_BIT])
      begin
         driveMask[sel]  = 1'b1;
         driveValue[sel] = altDrive.square;
      end
      driveMask = driveMask & ~forceIn;
   end

   // ==========================================================================
   // Input sensing
   always_comb
   begin
      altSense = '0;
      for (int p = 0; p < gpio_pkg::NUM_SERIAL; p++)
      begin
         altSense.rx[p]  = state_reg.levelSync[gpio_pkg::RX_LINE[p]];
         altSense.cts[p] = 1'b0;
         if (state_reg.ctsMapEn[p] && state_reg.ctsSel[p] < 5'(gpio_pkg::UPPER_BASE))
            altSense.cts[p] = state_reg.levelSync[state_reg.ctsSel[p][2:0]];
      end
   end

   // ==========================================================================
   // Route register image
   always_comb
   begin
      routeWord = '0;
      for (int p = 0; p < gpio_pkg::NUM_SERIAL; p++)
      begin
         routeWord[gpio_pkg::ROUTE_CTS_EN + p] = state_reg.ctsMapEn[p];
         routeWord[gpio_pkg::ROUTE_RTS_EN + p] = state_reg.rtsMapEn[p];
         routeWord[gpio_pkg::ROUTE_CTS_SEL + 4*p +: 4] = state_reg.ctsSel[p][3:0];
      end
      routeWord[gpio_pkg::ROUTE_RTS_SEL +: 5] = state_reg.rtsSel[0];
   end

   // ==========================================================================
   // Next state
   always_comb
   begin
      state_next           = state_reg;
      state_next.levelSync = pinIn.level;
      state_next.pins.value  = driveValue;
      state_next.pins.enable = ~driveMask;
      state_next.pslverr   = 1'b0;
      mergedWord           = '0;
      if (access && pwrite)
      begin
         if (paddr == gpio_pkg::OUT_VALUE_OFS)
         begin
            mergedWord = mergeBytes({15'h0000, state_reg.outValue}, pwdata, pstrb);
            state_next.outValue = mergedWord[16:0];
         end
         else if (paddr == gpio_pkg::OUT_ENABLE_OFS)
         begin
            mergedWord = mergeBytes({15'h0000, state_reg.outEnable}, pwdata, pstrb);
            state_next.outEnable = mergedWord[16:0];
         end
         else if (paddr == gpio_pkg::ALT_ENABLE_OFS)
         begin
            if (pstrb[0])
               state_next.altEnable = pwdata[4:0];
         end
         else if (paddr == gpio_pkg::ALT_ROUTE_OFS)
         begin
            mergedWord = mergeBytes(routeWord, pwdata, pstrb);
            for (int p = 0; p < gpio_pkg::NUM_SERIAL; p++)
            begin
               state_next.ctsMapEn[p] = mergedWord[gpio_pkg::ROUTE_CTS_EN + p];
               state_next.rtsMapEn[p] = mergedWord[gpio_pkg::ROUTE_RTS_EN + p];
               state_next.ctsSel[p]   = {1'b0, mergedWord[gpio_pkg::ROUTE_CTS_SEL + 4*p +: 4]};
               state_next.rtsSel[p]   = mergedWord[gpio_pkg::ROUTE_RTS_SEL +: 5];
            end
         end
      end
      if (psel && !penable && !pwrite)
      begin
         state_next.prdata = '0;
         if (paddr == gpio_pkg::OUT_VALUE_OFS)
            state_next.prdata = {15'h0000, state_reg.outValue};
         else if (paddr == gpio_pkg::OUT_ENABLE_OFS)
            state_next.prdata = {15'h0000, state_reg.outEnable};
         else if (paddr == gpio_pkg::LINE_LEVEL_OFS)
            state_next.prdata = {15'h0000, state_reg.levelSync};
         else if (paddr == gpio_pkg::PORT_LEVEL_OFS)
            state_next.prdata = {16'h0000,
               state_reg.levelSync[gpio_pkg::UPPER_BASE +: gpio_pkg::PORT_WIDTH],
               state_reg.levelSync[gpio_pkg::LOWER_BASE +: gpio_pkg::PORT_WIDTH]};
         else if (paddr == gpio_pkg::ALT_ENABLE_OFS)
            state_next.prdata = {27'h0000000, state_reg.altEnable};
         else if (paddr == gpio_pkg::ALT_ROUTE_OFS)
            state_next.prdata = routeWord;
         else if (paddr == gpio_pkg::LINE_DRIVE_OFS)
            state_next.prdata = {15'h0000, driveMask};
      end
      // Errors are registered at setup so that they stand through the access phase.
      if (psel && !penable && pwrite && paddr != gpio_pkg::OUT_VALUE_OFS
          && paddr != gpio_pkg::OUT_ENABLE_OFS && paddr != gpio_pkg::ALT_ENABLE_OFS
          && paddr != gpio_pkg::ALT_ROUTE_OFS && paddr != gpio_pkg::LINE_LEVEL_OFS
          && paddr != gpio_pkg::PORT_LEVEL_OFS && paddr != gpio_pkg::LINE_DRIVE_OFS)
         state_next.pslverr = 1'b1;
      if (psel && !penable && !pwrite && paddr > gpio_pkg::LINE_DRIVE_OFS)
         state_next.pslverr = 1'b1;
   end

   // ==========================================================================
   // Registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_reg             <= '0;
         state_reg.outValue    <= gpio_pkg::OUT_VALUE_RST;
         state_reg.outEnable   <= gpio_pkg::OUT_ENABLE_RST;
         state_reg.altEnable   <= gpio_pkg::ALT_ENABLE_RST;
         state_reg.pins.enable <= '1;
         state_reg.levelSync   <= '1;
      end
      else
         state_reg <= state_next;
   end

endmodule : gpio_lines

/* shared/gpio_pkg.sv */
/*
 Constants, register map and carrier types of the general-purpose line block.
 Assumes an APB master with 32-bit data and a single 200 MHz clock domain.
*/
// Summary of operation
// - Seventeen lines exist, sixteen in two byte ports and one line in neither port.
// - Lines eight to fifteen form the upper port, line eight at bit zero.
// - Lines zero to seven form the lower port, line number equal to bit position.
// - Each line has its own output enable, changeable without touching any other line; the code writes enables by byte lane, pstrb[2] for line 16 only.
// - After reset every output driver is off, so all lines are inputs.
// - Each line has a weak pull-up, so an undriven line reads high.
// - An enabled serial port or square-wave unit takes its lines over from the gpio logic.
// - An enabled serial port forces its receive line to input; disabling restores it.
// - An enabled serial port forces its transmit line to output; disabling restores it.
// - The clear-to-send input of a serial port may be remapped onto a main-connector line.
// - Any upper-port line or line sixteen may be a serial port's request-to-send output; the code routes only the value, the output enable sets direction.
// - The square-wave output is routed onto line sixteen.
// - While the square wave runs line sixteen is an output; afterwards it is restored.
package gpio_pkg;

   // ==========================================================================
   // Sizes
   localparam int NUM_LINES   = 17;
   localparam int NUM_SERIAL  = 4;
   localparam int PORT_WIDTH  = 8;
   localparam int LOWER_BASE  = 0;
   localparam int UPPER_BASE  = 8;
   localparam int UNPORTED    = 16;
   localparam int SEL_WIDTH   = 5;

   // ==========================================================================
   // Register byte offsets
   localparam logic [11:0] OUT_VALUE_OFS  = 12'h000;
   localparam logic [11:0] OUT_ENABLE_OFS = 12'h004;
   localparam logic [11:0] LINE_LEVEL_OFS = 12'h008;
   localparam logic [11:0] PORT_LEVEL_OFS = 12'h00C;
   localparam logic [11:0] ALT_ENABLE_OFS = 12'h010;
   localparam logic [11:0] ALT_ROUTE_OFS  = 12'h014;
   localparam logic [11:0] LINE_DRIVE_OFS = 12'h018;

   // ==========================================================================
   // Field positions
   localparam int ALT_SQUARE_BIT = 4;
   localparam int ROUTE_CTS_EN   = 0;
   localparam int ROUTE_RTS_EN   = 4;
   localparam int ROUTE_CTS_SEL  = 8;
   localparam int ROUTE_RTS_SEL  = 24;
   localparam int PORT_UPPER_POS = 8;

   // ==========================================================================
   // Reset values
   localparam logic [16:0] OUT_VALUE_RST  = 17'h1FFFF;
   localparam logic [16:0] OUT_ENABLE_RST = 17'h00000;
   localparam logic [4:0]  ALT_ENABLE_RST = 5'h00;

   // ==========================================================================
   // Fixed alternate-function line numbers
   localparam logic [4:0] RX_LINE [NUM_SERIAL] = '{5'h00, 5'h02, 5'h04, 5'h06};
   localparam logic [4:0] TX_LINE [NUM_SERIAL] = '{5'h01, 5'h03, 5'h05, 5'h07};

   // ==========================================================================
   // Types
   typedef struct packed {
      logic [16:0] level;
   } line_in_t;

   typedef struct packed {
      logic [16:0] value;
      logic [16:0] enable;
   } line_out_t;

   typedef struct packed {
      logic [3:0] tx;
      logic [3:0] rts;
      logic       square;
   } alt_drive_t;

   typedef struct packed {
      logic [3:0] rx;
      logic [3:0] cts;
   } alt_sense_t;

   typedef struct packed {
      logic        valid;
      logic [11:0] addr;
      logic        write;
      logic [31:0] wdata;
   } apb_req_t;

   typedef struct packed {
      logic [16:0] outValue;
      logic [16:0] outEnable;
      logic [4:0]  altEnable;
      logic [3:0]  ctsMapEn;
      logic [3:0]  rtsMapEn;
      logic [3:0][4:0] ctsSel;
      logic [3:0][4:0] rtsSel;
      logic [31:0] prdata;
      logic        pslverr;
      line_out_t   pins;
      logic [16:0] levelSync;
   } gpio_state_t;

endpackage : gpio_pkg

/* bench/gpio_lines_sva.sv */
/* Port assertions for the gpio line block.
 Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module gpio_lines_sva
(
   input wire logic                 clk,
   input wire logic                 reset,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic [3:0]           pstrb,
   input wire gpio_pkg::line_in_t   pinIn,
   input wire gpio_pkg::line_out_t  pinOut,
   input wire logic [16:0]          pullUpEn,
   input wire gpio_pkg::alt_drive_t altDrive,
   input wire gpio_pkg::alt_sense_t altSense
);
   // ==========
   // Shadow copies of direction and alternate enables.
   logic [16:0] oeH, m, rxM, txM, freeM;
   logic [4:0]  altH;
   logic [3:0]  rxH;
   assign m = {pstrb[2], {8{pstrb[1]}}, {8{pstrb[0]}}};
   assign rxM = {9'h000, 1'b0, altH[3], 1'b0, altH[2], 1'b0, altH[1], 1'b0, altH[0]};
   assign txM = rxM << 1;
   assign freeM = ~(rxM | txM | {altH[4], 16'h0000});
   always_ff @(posedge clk)
   begin
      rxH <= {pinIn.level[6], pinIn.level[4], pinIn.level[2], pinIn.level[0]};
      if (reset)
      begin
         oeH <= 17'h00000;
         altH <= 5'h00;
      end
      else if (psel && penable && pwrite)
      begin
         if (paddr == gpio_pkg::OUT_ENABLE_OFS)
            oeH <= (oeH & ~m) | (pwdata[16:0] & m);
         if (paddr == gpio_pkg::ALT_ENABLE_OFS && pstrb[0])
            altH <= pwdata[4:0];
      end
   end
   // ==========
   // Properties.
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_sq; $past(altH[4]); endsequence
   property p_reset_off; disable iff (1'b0) reset |=> pinOut.enable == 17'h1FFFF; endproperty
   property p_pullup; pullUpEn == 17'h1FFFF; endproperty
   property p_rx_in; (pinOut.enable & $past(rxM)) == $past(rxM); endproperty
   property p_tx_out; (pinOut.enable & $past(txM)) == 17'h00000; endproperty
   property p_dir; (pinOut.enable & $past(freeM)) == (~$past(oeH) & $past(freeM)); endproperty
   property p_tx_val; $past(altH[0]) |-> pinOut.value[1] == $past(altDrive.tx[0]); endproperty
   property p_sq_out; s_sq |-> !pinOut.enable[16]; endproperty
   property p_sq_val; s_sq |-> pinOut.value[16] == $past(altDrive.square); endproperty
   property p_rx_sense; (altSense.rx & altH[3:0]) == (rxH & altH[3:0]); endproperty
   a_reset_off: assert property (p_reset_off) else $error("drivers on after reset");
   a_pullup: assert property (p_pullup) else $error("pull-up off");
   a_rx_in: assert property (p_rx_in) else $error("receive line driven");
   a_tx_out: assert property (p_tx_out) else $error("transmit line idle");
   a_dir: assert property (p_dir) else $error("line direction wrong");
   a_tx_val: assert property (p_tx_val) else $error("transmit value wrong");
   a_sq_out: assert property (p_sq_out) else $error("square line not driven");
   a_sq_val: assert property (p_sq_val) else $error("square value wrong");
   a_rx_sense: assert property (p_rx_sense) else $error("receive level wrong");
endmodule : gpio_lines_sva
bind gpio_lines gpio_lines_sva u_sva (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pinIn(pinIn),
   .pinOut(pinOut), .pullUpEn(pullUpEn), .altDrive(altDrive), .altSense(altSense));

/* bench/pin_world.sv */
/* Model of the wires outside the block.
 Assumes extEn marks lines that an outside part drives to extVal. */
`timescale 1ns/100ps
module pin_world
(
   input wire gpio_pkg::line_out_t pinOut,
   input wire logic [16:0]         pullUpEn,
   input wire logic [16:0]         extEn,
   input wire logic [16:0]         extVal,
   output     gpio_pkg::line_in_t  pinIn
);
   // ==========
   // Wire level resolution.
   always_comb
   begin
      for (int i = 0; i < 17; i++)
      begin
         if (!pinOut.enable[i])
            pinIn.level[i] = pinOut.value[i];
         else if (extEn[i])
            pinIn.level[i] = extVal[i];
         else
            pinIn.level[i] = pullUpEn[i];
      end
   end
endmodule : pin_world

/* bench/gpio_lines_with_alt_function_mux_tb.sv */
/* Self-checking bench for the gpio line block.
 Assumes the pin model and the bound checker. */
`timescale 1ns/100ps
module gpio_lines_with_alt_function_mux_tb;
   // ==========
   // Signals and instances.
   logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er, pready, pslverr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [3:0] pstrb = 4'h0;
   logic [16:0] extEn = 17'h0, extVal = 17'h0, pullUpEn;
   gpio_pkg::line_in_t pinIn;
   gpio_pkg::line_out_t pinOut;
   gpio_pkg::alt_drive_t altDrive = '0;
   gpio_pkg::alt_sense_t altSense;
   int fails = 0, checked = 0;
   always #2.5 clk = ~clk;
   gpio_lines DUT (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut), .pullUpEn(pullUpEn),
      .altDrive(altDrive), .altSense(altSense));
   pin_world PW (.pinOut(pinOut), .pullUpEn(pullUpEn), .extEn(extEn), .extVal(extVal),
      .pinIn(pinIn));
   // ==========
   // Bus, compare and closing tasks.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic settle;
      repeat (3) @(posedge clk);
   endtask : settle
   task automatic end_of_test;
      $display("Checks %0d errors %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_of_test
   // ==========
   // Scenarios.
   task automatic t_reset;
      apb(1'b0, gpio_pkg::OUT_ENABLE_OFS, 32'h0, 4'hF);
      chk("oe reg", 32'h0, rd);
      chk("drive off", 32'h1FFFF, 32'(pinOut.enable));
      apb(1'b0, gpio_pkg::LINE_LEVEL_OFS, 32'h0, 4'hF);
      chk("levels", 32'h1FFFF, rd);
   endtask : t_reset
   task automatic t_ports;
      extEn <= 17'h0FF00;
      extVal <= 17'h03C00;
      apb(1'b1, gpio_pkg::OUT_VALUE_OFS, 32'hA5, 4'hF);
      apb(1'b1, gpio_pkg::OUT_ENABLE_OFS, 32'hFFFF, 4'h1);
      settle;
      chk("enable", 32'h1FF00, 32'(pinOut.enable));
      apb(1'b0, gpio_pkg::LINE_LEVEL_OFS, 32'h0, 4'hF);
      chk("lines", 32'h13CA5, rd);
      apb(1'b0, gpio_pkg::PORT_LEVEL_OFS, 32'h0, 4'hF);
      chk("ports", 32'h3CA5, rd);
   endtask : t_ports
   task automatic t_alt;
      altDrive <= '{tx: 4'hA, rts: 4'h0, square: 1'b1};
      apb(1'b1, gpio_pkg::ALT_ENABLE_OFS, 32'h1F, 4'h1);
      settle;
      chk("alt dir", 32'h0FF55, 32'(pinOut.enable));
      chk("alt val", 32'h10088, 32'(pinOut.value & 17'h100AA));
      chk("rx sense", 32'hF, 32'(altSense.rx));
      apb(1'b1, gpio_pkg::ALT_ENABLE_OFS, 32'h0, 4'h1);
      settle;
      chk("restored", 32'h1FF00, 32'(pinOut.enable));
   endtask : t_alt
   task automatic t_route;
      extEn <= 17'h00020;
      extVal <= 17'h00000;
      altDrive <= '0;
      apb(1'b1, gpio_pkg::OUT_ENABLE_OFS, 32'h10DF, 4'h7);
      apb(1'b1, gpio_pkg::ALT_ROUTE_OFS, 32'h0C000511, 4'hF);
      apb(1'b0, gpio_pkg::ALT_ROUTE_OFS, 32'h0, 4'hF);
      chk("route", 32'h0C000511, rd);
      apb(1'b1, gpio_pkg::ALT_ENABLE_OFS, 32'h1, 4'h1);
      settle;
      apb(1'b0, gpio_pkg::LINE_DRIVE_OFS, 32'h0, 4'hF);
      chk("drive mask", 32'h10DE, rd);
      chk("rts on", 32'h0, 32'({pinOut.enable[12], pinOut.value[12]}));
      chk("cts low", 32'h0, 32'(altSense.cts[0]));
      extVal <= 17'h00020;
      altDrive.rts <= 4'h1;
      settle;
      chk("rts high", 32'h1, 32'(pinOut.value[12]));
      chk("cts high", 32'h1, 32'(altSense.cts[0]));
      apb(1'b1, 12'h040, 32'hFFFFFFFF, 4'hF);
      chk("refused", 32'h1, 32'(er));
      apb(1'b0, gpio_pkg::OUT_ENABLE_OFS, 32'h0, 4'hF);
      chk("oe kept", 32'h10DF, rd);
      chk("no error", 32'h0, 32'(er));
      apb(1'b0, 12'h040, 32'h0, 4'hF);
      chk("read refused", 32'h1, 32'(er));
   endtask : t_route
   initial
   begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_reset;
      t_ports;
      t_alt;
      t_route;
      end_of_test;
   end
   initial
   begin
      repeat (4000) @(posedge clk);
      fails++;
      end_of_test;
   end
endmodule : gpio_lines_with_alt_function_mux_tb
